// ### verilog/arp_pkg.sv
// Constants, format decode and carrier types for the readout block
package arp_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NCH = 8;
   localparam int BITS = 24;
   localparam int FRAME_W = NCH * BITS;
   localparam int BCNT_W = 5;
   localparam logic [BCNT_W-1:0] BCNT_FULL = 5'h18;
   // ----------------------------------------
   // Timing (master clock cycles, conversions)
   // ----------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int CONV_CYCLES = 256;
   localparam int CONV_W = 8;
   localparam logic [CONV_W-1:0] CONV_LAST = 8'hFF;
   localparam logic [CONV_W-1:0] CONV_PRE = 8'h01;
   localparam int PD_MIN_CLK = 2;
   localparam logic [1:0] PD_CNT_LAST = 2'h1;
   localparam int SET_W = 8;
   // Power-up targets include the partial first conversion
   localparam logic [SET_W-1:0] SETTLE_SPI = 8'h82;
   localparam logic [SET_W-1:0] SETTLE_FS = 8'h81;
   // Restart starts one conversion ahead: 129 SPI, 128 frame-sync
   localparam logic [SET_W-1:0] SETTLE_RESTART = 8'h01;
   // ----------------------------------------
   // Pin vector layout and reset values
   // ----------------------------------------
   localparam int IN_W = 15;
   localparam int SCLK_BIT = 0;
   localparam int FRAME_SYNC_IN_BIT = 1;
   localparam int DIN_BIT = 2;
   localparam int RESTART_BIT = 3;
   localparam int PD_LO = 4;
   localparam int FMT_LO = 12;
   localparam logic [IN_W-1:0] PIN_RST = 15'h0000;
   localparam logic DATA_READY_N_RST = 1'b1;
   // ----------------------------------------
   // Format select codes
   // ----------------------------------------
   localparam logic [2:0] FMT_SPI_DYN = 3'h0;
   localparam logic [2:0] FMT_SPI_FIX = 3'h1;
   localparam logic [2:0] FMT_SPI_DISC = 3'h2;
   localparam logic [2:0] FMT_FS_DYN = 3'h3;
   localparam logic [2:0] FMT_FS_FIX = 3'h4;
   localparam logic [2:0] FMT_FS_DISC = 3'h5;
   localparam logic [2:0] FMT_MOD = 3'h6;

   typedef struct packed {
      logic fs;
      logic discrete;
      logic fixed;
      logic modulator;
   } arp_fmt_type;

   function automatic arp_fmt_type arp_decode(input logic [2:0] code);
      arp_fmt_type f;
      f.fs = (code == FMT_FS_DYN) || (code == FMT_FS_FIX) || (code == FMT_FS_DISC);
      f.discrete = (code == FMT_SPI_DISC) || (code == FMT_FS_DISC);
      f.fixed = (code == FMT_SPI_FIX) || (code == FMT_FS_FIX);
      f.modulator = (code == FMT_MOD);
      return f;
   endfunction
endpackage

// ### verilog/arp_readout.sv
// Readout, power-down and output format logic of the octal converter
`timescale 1ns/100ps
// Summary of operation
// - Frame-sync: valid data 128 conversions after restart returns high.
// - Power-down input high again powers the channel up and restarts it.
// - All channels down: biasing off, outputs still driven.
// - SPI: powered-up channel valid 129 to 130 conversions later.
// - Frame-sync: powered-up channel valid 128 to 129 conversions later.
// - Power changes never disturb data of running channels.
// - Freshly powered channels align with each other without restart.
// - TDM fixed: down channel sends zeros; dynamic: higher channels fill slot.
// - Discrete: powered-down channel output carries zeros.
// - Dynamic TDM: frame widens only once new channel data are valid.
// - Format select decodes SPI, frame-sync, TDM/discrete, fixed/dynamic, modulator.
// - Both protocols share shift clock, ready/sync line, data outputs, chain input.
// - SPI: ready falls when data available; shift MSB first on clock falls.
// - Chain input captured on each falling shift-clock edge without a same-cycle frame load in TDM formats; discrete shifts in zeros.
// - Modulator mode turns shift-clock line into modulator clock output.
// - SPI ready goes low with data, high at next shift-clock fall or when the timer reaches CONV_PRE, whichever comes first.
// - Discrete: outputs forced to zero after the 24th shift-clock edge.
module arp_readout import arp_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Host-side pins
   input wire logic sclk_in,
   input wire logic frame_sync_in,
   input wire logic din_in,
   input wire logic restart_n_in,
   input wire logic [NCH-1:0] channel_powerdown_n,
   input wire logic [2:0] format_sel,
   // Converter core
   input wire logic [NCH-1:0][BITS-1:0] sample_data,
   input wire logic [NCH-1:0] mod_bits,
   // Pin outputs
   output logic [NCH-1:0] dout,
   output logic data_ready_n,
   output logic data_ready_oe,
   output logic sclk_out,
   output logic sclk_oe,
   // Status
   output logic bias_en,
   output logic [NCH-1:0] chan_valid
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [IN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r, pin_qd_r;
   wire logic [IN_W-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
   wire logic [IN_W-1:0] pin_q_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_q_r);
   wire logic [IN_W-1:0] pin_raw = {format_sel, channel_powerdown_n, restart_n_in,
                                    din_in, frame_sync_in, sclk_in};

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_s1_r <= PIN_RST;
         pin_s2_r <= PIN_RST;
         pin_s3_r <= PIN_RST;
         pin_q_r <= PIN_RST;
         pin_qd_r <= PIN_RST;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_q_r <= pin_q_nxt;
         pin_qd_r <= pin_q_r;
      end
   end

   wire logic sclk_fall = pin_qd_r[SCLK_BIT] & ~pin_q_r[SCLK_BIT];
   wire logic frame_sync_in_rise = ~pin_qd_r[FRAME_SYNC_IN_BIT] & pin_q_r[FRAME_SYNC_IN_BIT];
   wire logic din_q = pin_q_r[DIN_BIT];
   wire logic restart_q = pin_q_r[RESTART_BIT];
   wire logic [NCH-1:0] pd_n_q = pin_q_r[PD_LO +: NCH];
   wire arp_fmt_type fmt = arp_decode(pin_q_r[FMT_LO +: 3]);
   // ----------------------------------------
   // Conversion timer, shared by all channels
   // ----------------------------------------
   logic [CONV_W-1:0] conv_cnt_r;
   logic tick_d_r;
   wire logic conv_tick = restart_q && (conv_cnt_r == '0);
   wire logic [CONV_W-1:0] conv_cnt_nxt = restart_q ? conv_cnt_r - 1'b1 : CONV_LAST;

   always_ff @(posedge clock) begin
      if (rst) begin
         conv_cnt_r <= CONV_LAST;
         tick_d_r <= 1'b0;
      end else begin
         conv_cnt_r <= conv_cnt_nxt;
         tick_d_r <= conv_tick;
      end
   end
   // ----------------------------------------
   // Per-channel power and settling
   // ----------------------------------------
   logic [NCH-1:0] chan_on_r, chan_valid_r;
   logic [NCH-1:0][1:0] pd_cnt_r;
   logic [NCH-1:0][SET_W-1:0] settle_r;
   wire logic [SET_W-1:0] settle_target = fmt.fs ? SETTLE_FS : SETTLE_SPI;
   wire logic [NCH-1:0] valid_nxt;

   genvar k;
   generate
      for (k = 0; k < NCH; k++) begin : g_ch
         wire logic pd_done = !pd_n_q[k] && (pd_cnt_r[k] == PD_CNT_LAST);
         wire logic on_nxt = pd_n_q[k] ? 1'b1 : (chan_on_r[k] && !pd_done);
         wire logic hit = conv_tick && (settle_r[k] == settle_target - 1'b1);
         wire logic [SET_W-1:0] set_nxt = !chan_on_r[k] ? '0 :
                                          !restart_q ? SETTLE_RESTART :
                                          (conv_tick && !chan_valid_r[k]) ?
                                          settle_r[k] + 1'b1 : settle_r[k];
         wire logic val_nxt = chan_on_r[k] && restart_q && (chan_valid_r[k] || hit);
         assign valid_nxt[k] = val_nxt;
         always_ff @(posedge clock) begin
            if (rst) begin
               pd_cnt_r[k] <= '0;
               chan_on_r[k] <= 1'b0;
               settle_r[k] <= '0;
               chan_valid_r[k] <= 1'b0;
            end else begin
               pd_cnt_r[k] <= pd_n_q[k] ? 2'h0 : (pd_done ? pd_cnt_r[k] : pd_cnt_r[k] + 1'b1);
               chan_on_r[k] <= on_nxt;
               settle_r[k] <= set_nxt;
               chan_valid_r[k] <= val_nxt;
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // Frame build: fixed or packed slots
   // ----------------------------------------
   logic [FRAME_W-1:0] frame_nxt, frame_r;
   always_comb begin
      int slot;
      slot = 0;
      frame_nxt = '0;
      for (int c = 0; c < NCH; c++) begin
         // Freshly valid channels join the frame latched at this tick
         if (valid_nxt[c] || fmt.fixed || fmt.discrete) begin
            frame_nxt[FRAME_W-1-BITS*slot -: BITS] =
               valid_nxt[c] ? sample_data[c] : '0;
            slot = slot + 1;
         end
      end
   end
   // ----------------------------------------
   // Shift register and output pins
   // ----------------------------------------
   logic [FRAME_W-1:0] shift_r;
   logic [BCNT_W-1:0] bcnt_r;
   logic [NCH-1:0] dout_r;
   logic data_ready_n_r, data_ready_n_oe_r, sclk_out_r, sclk_oe_r, bias_r;
   wire logic load = fmt.fs ? frame_sync_in_rise : tick_d_r;
   wire logic spi_load = load && !fmt.fs && !fmt.modulator && (|chan_valid_r);
   logic [FRAME_W-1:0] shift_disc;
   logic [NCH-1:0] dout_nxt;
   generate
      for (k = 0; k < NCH; k++) begin : g_out
         assign shift_disc[FRAME_W-1-BITS*k -: BITS] =
            {shift_r[FRAME_W-2-BITS*k -: BITS-1], 1'b0};
         assign dout_nxt[k] = fmt.modulator ? mod_bits[k] :
                              fmt.discrete ? (shift_r[FRAME_W-1-BITS*k] && bcnt_r < BCNT_FULL) :
                              (k == 0) ? shift_r[FRAME_W-1] : 1'b0;
      end
   endgenerate
   wire logic [FRAME_W-1:0] shift_tdm = {shift_r[FRAME_W-2:0], din_q};
   wire logic data_ready_n_nxt = spi_load ? 1'b0 :
                         (sclk_fall || conv_cnt_r == CONV_PRE) ? 1'b1 : data_ready_n_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         frame_r <= '0;
         shift_r <= '0;
         bcnt_r <= '0;
         dout_r <= '0;
         data_ready_n_r <= DATA_READY_N_RST;
         data_ready_n_oe_r <= 1'b0;
         sclk_out_r <= 1'b0;
         sclk_oe_r <= 1'b0;
         bias_r <= 1'b0;
      end else begin
         if (conv_tick) begin
            frame_r <= frame_nxt;
         end
         if (load) begin
            shift_r <= frame_r;
            bcnt_r <= '0;
         end else if (sclk_fall) begin
            shift_r <= fmt.discrete ? shift_disc : shift_tdm;
            bcnt_r <= (bcnt_r == BCNT_FULL) ? bcnt_r : bcnt_r + 1'b1;
         end
         dout_r <= dout_nxt;
         data_ready_n_r <= data_ready_n_nxt;
         data_ready_n_oe_r <= !fmt.fs && !fmt.modulator;
         sclk_oe_r <= fmt.modulator;
         sclk_out_r <= fmt.modulator ? ~sclk_out_r : 1'b0;
         bias_r <= |chan_on_r;
      end
   end

   assign dout = dout_r;
   assign data_ready_n = data_ready_n_r;
   assign data_ready_oe = data_ready_n_oe_r;
   assign sclk_out = sclk_out_r;
   assign sclk_oe = sclk_oe_r;
   assign bias_en = bias_r;
   assign chan_valid = chan_valid_r;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_pd_two_clk;
      @(posedge clock) disable iff (rst)
      $fell(chan_on_r[1]) |-> !$past(pd_n_q[1], 1) && !$past(pd_n_q[1], 2);
   endproperty
   a_pd_two_clk: assert property (p_pd_two_clk) else $error("early power-down");

   property p_power_up;
      @(posedge clock) disable iff (rst)
      $rose(pd_n_q[1]) && !chan_on_r[1] |=> chan_on_r[1] && !chan_valid_r[1];
   endproperty
   a_power_up: assert property (p_power_up) else $error("power-up wrong");

   property p_micro;
      @(posedge clock) disable iff (rst)
      !(|chan_on_r) |=> !bias_en;
   endproperty
   a_micro: assert property (p_micro) else $error("bias on while all down");

   property p_settle;
      @(posedge clock) disable iff (rst)
      $rose(chan_valid_r[1]) && $past(restart_q) && $past(chan_on_r[1]) |->
         $past(settle_r[1]) == $past(settle_target) - 1'b1 && $past(conv_tick);
   endproperty
   a_settle: assert property (p_settle) else $error("settle count wrong");

   property p_restart;
      @(posedge clock) disable iff (rst)
      !restart_q |=> chan_valid_r == '0 && conv_cnt_r == CONV_LAST;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not held");

   property p_fixed_zero;
      @(posedge clock) disable iff (rst)
      conv_tick && fmt.fixed && !valid_nxt[0] |=> frame_r[FRAME_W-1 -: BITS] == '0;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("down slot not zero");

   property p_disc_zero;
      @(posedge clock) disable iff (rst)
      fmt.discrete && !fmt.modulator && bcnt_r == BCNT_FULL |=> dout_r == '0;
   endproperty
   a_disc_zero: assert property (p_disc_zero) else $error("discrete not zero");

   property p_data_ready_n_release;
      @(posedge clock) disable iff (rst)
      !data_ready_n_r && sclk_fall && !spi_load |=> data_ready_n_r;
   endproperty
   a_data_ready_n_release: assert property (p_data_ready_n_release) else $error("ready not released");

   property p_shift;
      @(posedge clock) disable iff (rst)
      sclk_fall && !load && !fmt.discrete |=>
         shift_r == {$past(shift_r[FRAME_W-2:0]), $past(din_q)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_mod_clk;
      @(posedge clock) disable iff (rst)
      fmt.modulator ##1 fmt.modulator |=> sclk_oe && sclk_out != $past(sclk_out);
   endproperty
   a_mod_clk: assert property (p_mod_clk) else $error("no modulator clock");
endmodule

// ### verif/arp_host.sv
// Host model that reads serial frames from the readout block
`timescale 1ns/100ps
module arp_host import arp_pkg::*; (
   // Clock
   input wire logic clock,
   // Device pins
   input wire logic data_ready_n,
   input wire logic [NCH-1:0] dout,
   output logic sclk,
   output logic din
);
   logic [NCH-1:0] cap [0:31];
   logic ok;
   initial begin
      sclk = 1'b0;
      din = 1'b0;
      ok = 1'b0;
   end
   // Fresh frame: ready high, then low; shift clock idles low between frames
   task automatic read_frame(input int n);
      int i;
      ok = 1'b0;
      for (i = 0; i < 600 && data_ready_n !== 1'b1; i++) @(negedge clock);
      for (i = 0; i < 600 && data_ready_n !== 1'b0; i++) @(negedge clock);
      if (data_ready_n === 1'b0) begin
         ok = 1'b1;
         repeat (2) @(posedge clock);
         for (i = 0; i < n; i++) begin
            #2 sclk = 1'b1;
            #96 cap[i] = dout;
            #4 sclk = 1'b0;
            #98;
         end
      end
   endtask
endmodule

// ### verif/tb.sv
// Self-checking testbench for the readout block
`timescale 1ns/100ps
module tb import arp_pkg::*;;
   localparam logic [23:0] D1 = 24'hC3A596;
   localparam logic [23:0] D2 = 24'h5AF00F;
   localparam logic [4:0] ROWS [0:6] = '{{FMT_SPI_DYN, 2'h2}, {FMT_SPI_FIX, 2'h2},
      {FMT_SPI_DISC, 2'h2}, {FMT_FS_DYN, 2'h0}, {FMT_FS_FIX, 2'h0}, {FMT_FS_DISC, 2'h0},
      {FMT_MOD, 2'h1}};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic restart_n = 1'b1;
   logic [NCH-1:0] pd_n = 8'h00;
   logic [2:0] fmt = 3'h0;
   logic [NCH-1:0][BITS-1:0] sample = {{5{24'h7E81E7}}, D2, D1, 24'h7E81E7};
   logic [NCH-1:0] mod_bits = 8'h5A;
   logic [7:0] fcnt = 8'h00;
   logic sclk, din, data_ready_n_n, data_ready_n_oe, sclk_out, sclk_oe, bias_en, s;
   logic [NCH-1:0] dout, chan_valid;
   int n_fail = 0;
   int n_compared = 0;
   int i;
   always #12.5 clock = ~clock;
   always @(posedge clock) fcnt <= fcnt + 8'h01;
   arp_readout dut (.clock(clock), .rst(rst), .sclk_in(sclk), .frame_sync_in(fcnt[7]),
      .din_in(din), .restart_n_in(restart_n), .channel_powerdown_n(pd_n), .format_sel(fmt),
      .sample_data(sample), .mod_bits(mod_bits), .dout(dout), .data_ready_n(data_ready_n_n),
      .data_ready_oe(data_ready_n_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .bias_en(bias_en),
      .chan_valid(chan_valid));
   arp_host host (.clock(clock), .data_ready_n(data_ready_n_n), .dout(dout), .sclk(sclk), .din(din));
   // ----------------------------------------
   // Checking tasks
   // ----------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_valid(input int ch, input int lo, input int hi);
      int c;
      for (c = 0; c < hi + 16 && chan_valid[ch] !== 1'b1; c++) @(negedge clock);
      n_compared++;
      if (c < lo || c > hi) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, c, hi);
      end
   endtask
   task automatic frame(input logic [29:0] e0, input logic [29:0] e1);
      logic [29:0] g0, g1;
      int k;
      host.read_frame(30);
      for (k = 0; k < 30; k++) begin
         g0[29-k] = host.cap[k][0];
         g1[29-k] = host.cap[k][1];
      end
      cmp(32'(host.ok), 32'h1);
      cmp(32'(g0), 32'(e0));
      cmp(32'(g1), 32'(e1));
   endtask
   task automatic set_fmt(input logic [2:0] f);
      @(posedge clock);
      fmt <= f;
      repeat (8) @(negedge clock);
   endtask
   task automatic set_pd(input logic [NCH-1:0] v, input int n);
      @(posedge clock);
      pd_n <= v;
      repeat (n) @(negedge clock);
   endtask
   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(negedge clock);
      cmp({dout, data_ready_n_n, data_ready_n_oe, sclk_out, sclk_oe, bias_en, chan_valid}, 32'h01000);
      @(posedge clock);
      rst <= 1'b0;
      $display("test reset done");
      for (i = 0; i < 7; i++) begin
         set_fmt(ROWS[i][4:2]);
         cmp({data_ready_n_oe, sclk_oe, bias_en}, {ROWS[i][1:0], 1'b0});
         s = sclk_out;
         @(negedge clock);
         cmp(32'(sclk_out ^ s), 32'(ROWS[i][0]));
      end
      cmp(32'(dout), 32'(mod_bits));
      $display("test formats done");
      set_fmt(FMT_SPI_DYN);
      set_pd(8'h02, 3);
      set_pd(8'h06, 8);
      cmp(32'(bias_en), 32'h1);
      wait_valid(1, 129 * 256 - 16, 130 * 256 + 8);
      cmp(32'(chan_valid), 32'h06);
      $display("test power-up done");
      frame({D1, D2[23:18]}, 30'h0);
      cmp(32'(data_ready_n_n), 32'h1);
      set_fmt(FMT_SPI_FIX);
      frame({24'h0, D1[23:18]}, 30'h0);
      set_fmt(FMT_SPI_DISC);
      frame(30'h0, {D1, 6'h0});
      $display("test readout done");
      set_pd(8'h02, 1);
      set_pd(8'h06, 8);
      cmp(32'(chan_valid), 32'h06);
      set_pd(8'h02, 8);
      cmp(32'(chan_valid), 32'h02);
      set_fmt(FMT_SPI_DYN);
      frame({D1, 6'h0}, 30'h0);
      $display("test power-down done");
      set_fmt(FMT_FS_DYN);
      @(posedge clock);
      restart_n <= 1'b0;
      repeat (8) @(negedge clock);
      cmp({data_ready_n_oe, chan_valid}, 32'h0);
      @(posedge clock);
      restart_n <= 1'b1;
      wait_valid(1, 127 * 256, 128 * 256 + 8);
      repeat (520) @(negedge clock);
      cmp(32'(dout), 32'(D1[23]));
      set_pd(8'h00, 8);
      cmp({bias_en, chan_valid}, 32'h0);
      $display("test restart done");
      close_out();
   end
   initial begin
      #(80000 * 25);
      n_fail++;
      close_out();
   end
endmodule
